// ==== design/txbis_input_select.sv ====
/*
 * Transmit input select for one 10-gigabit lane: splits the lane input bus,
 * routes each written word either to the encoder/scrambler path or, as a raw
 * 66-bit block, straight to the gearbox.
 * Assumes the encoder, scrambler and gearbox sit downstream on the same clock,
 * and the user fabric drives the lane bus synchronously to that clock.
 */
// How it works
// [R1] Control bit i flags payload byte i as a control byte.
// [R2] Force flag high sends same-cycle payload and header straight to gearbox.
// [R3] Force flag low with encoder bypass off resumes encoding and scrambling of payload and control.
// [R4] Raw mode joins control bits 1..0 as header with payload into 66 bits.
// [R5] Encoder bypass setting also builds the 66-bit block from user inputs.
// [R6] When header comes from control, control bits 7..2 are ignored.
// [R7] Force selection applies per cycle to that cycle's data, no offset.
// [R8] Force low, bypass off: encoder first, then scrambler, then gearbox.
// [R9] User pulses write strobe per word.
// [R10] Reserved bits between force flag and strobe are ignored.
`timescale 1ns/1ps

module txbis_input_select
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Static lane setting
    input wire logic ten_gig_ethernet_setting,
    input wire logic encoder_bypass,
    // User transmit bus
    input wire logic [79:0] lane_tx_input_bus,
    // Encoder path
    output logic encode_valid_q,
    output txbis_pkg::txbis_encode_type encode_word_q,
    // Raw path to gearbox
    output logic raw_valid_q,
    output logic [65:0] raw_block_q
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic [63:0] wide_payload_word;
    wire logic [7:0] control_word;
    wire logic force_raw;
    wire logic write_strobe;
    wire logic take_word;
    wire logic raw_select;
    wire txbis_pkg::txbis_path_type path;
    wire txbis_pkg::txbis_raw_type raw_word;
    wire txbis_pkg::txbis_encode_type enc_word;

    assign wide_payload_word = lane_tx_input_bus[txbis_pkg::PAYLOAD_LSB +: 64];
    // Byte i of payload is qualified by control bit i; kept together [R1]
    assign control_word = lane_tx_input_bus[txbis_pkg::CONTROL_LSB +: 8];
    assign force_raw = lane_tx_input_bus[txbis_pkg::FORCE_BIT];
    // Bits 78..73 are not decoded at all [R10]
    assign write_strobe = lane_tx_input_bus[txbis_pkg::WRITE_BIT];
    // A word moves only on the write strobe in this setting [R9]
    assign take_word = ten_gig_ethernet_setting & write_strobe;
    // Same-cycle selection, no latch of the force flag [R7] [R5]
    assign raw_select = force_raw | encoder_bypass;
    assign path = raw_select ? txbis_pkg::TXBIS_PATH_RAW : txbis_pkg::TXBIS_PATH_ENCODE;
    // Header is control bits 1..0 only; 7..2 dropped [R4] [R6]
    assign raw_word = '{header: control_word[1:0], payload: wide_payload_word};
    assign enc_word = '{control: control_word, payload: wide_payload_word};

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            raw_valid_q <= 1'h0;
            raw_block_q <= txbis_pkg::BLOCK_RESET;
        end
        else
        begin
            raw_valid_q <= take_word & (path == txbis_pkg::TXBIS_PATH_RAW); // [R2]
            raw_block_q <= raw_word; // [R4]
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            encode_valid_q <= 1'h0;
            encode_word_q <= '{control: txbis_pkg::CONTROL_RESET,
                               payload: txbis_pkg::PAYLOAD_RESET};
        end
        else
        begin
            // Encoder then scrambler then gearbox downstream [R3] [R8]
            encode_valid_q <= take_word & (path == txbis_pkg::TXBIS_PATH_ENCODE);
            encode_word_q <= enc_word; // [R1]
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_raw_same_cycle;
        @(posedge clock) disable iff (!reset_n)
        (take_word && force_raw) |=> (raw_valid_q && !encode_valid_q);
    endproperty
    a_raw_same_cycle: assert property (p_raw_same_cycle) else $error("raw word not routed"); // [R2]

    property p_encode_resume;
        @(posedge clock) disable iff (!reset_n)
        (take_word && !force_raw && !encoder_bypass) |=> (encode_valid_q && !raw_valid_q);
    endproperty
    a_encode_resume: assert property (p_encode_resume) else $error("encode word not routed"); // [R3]

    property p_block_form;
        @(posedge clock) disable iff (!reset_n)
        take_word && force_raw |=>
            raw_block_q == {$past(control_word[1:0]), $past(wide_payload_word)};
    endproperty
    a_block_form: assert property (p_block_form) else $error("66-bit block malformed"); // [R4]

    property p_bypass_raw;
        @(posedge clock) disable iff (!reset_n)
        (take_word && encoder_bypass) |=> raw_valid_q;
    endproperty
    a_bypass_raw: assert property (p_bypass_raw) else $error("bypass not raw"); // [R5]

    property p_high_control_ignored;
        @(posedge clock) disable iff (!reset_n)
        raw_valid_q |-> raw_block_q[65:64] == $past(lane_tx_input_bus[txbis_pkg::CONTROL_LSB +: 2]);
    endproperty
    a_high_control_ignored: assert property (p_high_control_ignored) else $error("header bits"); // [R6]

    property p_no_offset;
        @(posedge clock) disable iff (!reset_n)
        (take_word && force_raw) ##1 (take_word && !force_raw && !encoder_bypass)
            |=> encode_valid_q;
    endproperty
    a_no_offset: assert property (p_no_offset) else $error("force selection lagged"); // [R7]

    property p_encode_data;
        @(posedge clock) disable iff (!reset_n)
        encode_valid_q
            |-> encode_word_q.payload == $past(lane_tx_input_bus[txbis_pkg::PAYLOAD_LSB +: 64]);
    endproperty
    a_encode_data: assert property (p_encode_data) else $error("encode payload wrong"); // [R8]

    property p_no_strobe;
        @(posedge clock) disable iff (!reset_n)
        !take_word |=> !(raw_valid_q || encode_valid_q);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("word without strobe"); // [R9]

    property p_exclusive;
        @(posedge clock) disable iff (!reset_n)
        !(raw_valid_q && encode_valid_q);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both paths valid"); // [R2]

    property p_reserved_ignored;
        @(posedge clock) disable iff (!reset_n)
        $past(reset_n) |->
            (raw_valid_q || encode_valid_q) ==
                $past(ten_gig_ethernet_setting && lane_tx_input_bus[txbis_pkg::WRITE_BIT]);
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved bits used"); // [R10]

    property p_bypass_no_encode;
        @(posedge clock) disable iff (!reset_n)
        (take_word && encoder_bypass)
            |=> !encode_valid_q;
    endproperty
    a_bypass_no_encode: assert property (p_bypass_no_encode) else $error("bypass encoded"); // [R5]

    property p_bypass_block;
        @(posedge clock) disable iff (!reset_n)
        (take_word && encoder_bypass)
            |=> raw_block_q == {$past(control_word[1:0]), $past(wide_payload_word)};
    endproperty
    a_bypass_block: assert property (p_bypass_block) else $error("bypass block malformed"); // [R5]

    property p_setting_gate;
        @(posedge clock) disable iff (!reset_n)
        !ten_gig_ethernet_setting
            |=> !(raw_valid_q || encode_valid_q);
    endproperty
    a_setting_gate: assert property (p_setting_gate) else $error("word taken while disabled"); // [R9]

    property p_raw_payload;
        @(posedge clock) disable iff (!reset_n)
        raw_valid_q
            |-> raw_block_q[63:0] == $past(lane_tx_input_bus[txbis_pkg::PAYLOAD_LSB +: 64]);
    endproperty
    a_raw_payload: assert property (p_raw_payload) else $error("raw payload wrong"); // [R2]

    property p_raw_cause;
        @(posedge clock) disable iff (!reset_n)
        raw_valid_q
            |-> $past(take_word && (force_raw || encoder_bypass));
    endproperty
    a_raw_cause: assert property (p_raw_cause) else $error("raw block without cause"); // [R2]

    property p_encode_control;
        @(posedge clock) disable iff (!reset_n)
        encode_valid_q
            |-> encode_word_q.control == $past(lane_tx_input_bus[txbis_pkg::CONTROL_LSB +: 8]);
    endproperty
    a_encode_control: assert property (p_encode_control) else $error("control word wrong"); // [R1]

    property p_encode_order;
        @(posedge clock) disable iff (!reset_n)
        encode_valid_q
            |-> $past(take_word && !force_raw && !encoder_bypass);
    endproperty
    a_encode_order: assert property (p_encode_order) else $error("encode without cause"); // [R8]

    property p_force_back;
        @(posedge clock) disable iff (!reset_n)
        (take_word && !force_raw && !encoder_bypass) ##1 (take_word && force_raw)
            |=> raw_valid_q;
    endproperty
    a_force_back: assert property (p_force_back) else $error("force selection late"); // [R7]

    property p_no_force_latch;
        @(posedge clock) disable iff (!reset_n)
        (take_word && force_raw) ##1 (take_word && !force_raw && !encoder_bypass)
            |=> !raw_valid_q;
    endproperty
    a_no_force_latch: assert property (p_no_force_latch) else $error("force flag held over"); // [R7]

endmodule

// ==== design/txbis_pkg.sv ====
/*
 * Package for the transmit 66-bit block input select stage: lane bus layout,
 * carrier structs and path selection codes.
 * Assumes a single transmit clock domain shared with the user fabric.
 */
package txbis_pkg;

    // ------------------------------------------------------------------
    // Lane input bus layout
    // ------------------------------------------------------------------
    localparam int BUS_WIDTH = 80;
    localparam int PAYLOAD_WIDTH = 64;
    localparam int CONTROL_WIDTH = 8;
    localparam int HEADER_WIDTH = 2;
    localparam int BLOCK_WIDTH = 66;
    localparam int PAYLOAD_LSB = 0;
    localparam int CONTROL_LSB = 64;
    localparam int FORCE_BIT = 72;
    localparam int RESERVED_LSB = 73;
    localparam int RESERVED_MSB = 78;
    localparam int WRITE_BIT = 79;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [63:0] PAYLOAD_RESET = 64'h0000000000000000;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [65:0] BLOCK_RESET = 66'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef enum logic {TXBIS_PATH_ENCODE, TXBIS_PATH_RAW} txbis_path_type;

    typedef struct packed {
        logic [7:0] control;
        logic [63:0] payload;
    } txbis_encode_type;

    typedef struct packed {
        logic [1:0] header;
        logic [63:0] payload;
    } txbis_raw_type;

endpackage

// ==== testbench/txbis_input_select_tb.sv ====
/* Self-checking bench for the transmit input select stage.
   Assumes the user model drives the bus from values set at the falling edge. */
`timescale 1ns/1ps
module txbis_input_select_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic setting = 1'b1;
    logic bypass = 1'b0;
    logic send = 1'b0;
    logic frc = 1'b0;
    logic [5:0] rsv = 6'h00;
    logic [7:0] ctl = 8'h00;
    logic [63:0] dat = 64'h0000000000000000;
    logic [79:0] bus;
    logic enc_v;
    logic raw_v;
    txbis_pkg::txbis_encode_type enc_w;
    logic [65:0] raw_b;
    logic [72:0] exp_q[$];
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    txbis_user_model u_txbis_user_model (.send(send), .force_raw(frc), .rsv(rsv),
        .control(ctl), .payload(dat), .lane_tx_input_bus(bus));
    txbis_input_select u_txbis_input_select (.clock(clock), .reset_n(reset_n),
        .ten_gig_ethernet_setting(setting), .encoder_bypass(bypass),
        .lane_tx_input_bus(bus), .encode_valid_q(enc_v), .encode_word_q(enc_w),
        .raw_valid_q(raw_v), .raw_block_q(raw_b));
    task automatic check(string name, logic [72:0] seen, logic [72:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One bus cycle; the expected output is noted when the word is taken
    task automatic word(logic s, logic f, logic [5:0] r);
        @(negedge clock);
        send = s;
        frc = f;
        rsv = r;
        ctl = 8'($urandom);
        dat = {$urandom, $urandom};
        if (s && setting)
            exp_q.push_back((f || bypass) ? {1'b1, 6'h00, ctl[1:0], dat} : {1'b0, ctl, dat});
    endtask
    // ----
    // Output watcher
    // ----
    always @(negedge clock)
    begin
        if (reset_n && (raw_v === 1'b1 || enc_v === 1'b1) && exp_q.size() == 0)
            check("unexpected_valid", 73'h1, 73'h0);
        else if (reset_n && raw_v === 1'b1)
            check("raw_block", {1'b1, 6'h00, raw_b}, exp_q.pop_front());
        else if (reset_n && enc_v === 1'b1)
            check("encode_word", {1'b0, enc_w}, exp_q.pop_front());
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 1000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    // ----
    // Tests: mixed force, bypass, setting low, reserved bits set
    // ----
    initial
    begin
        void'($urandom(96733));
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            @(negedge clock);
            bypass = (t == 1);
            setting = (t != 2);
            repeat (24) word(1'($urandom), 1'($urandom), (t == 3) ? 6'($urandom) : 6'h00);
            word(1'b0, 1'b0, 6'h00);
            repeat (2) @(negedge clock);
            $display("test %0d done", t);
        end
        check("queue_left", 73'(exp_q.size()), 73'h0);
        close_out();
    end
endmodule

// ==== testbench/txbis_user_model.sv ====
/* User fabric model that drives the lane transmit bus.
   Assumes the bench changes its inputs at the falling edge. */
`timescale 1ns/1ps
module txbis_user_model
(
    // Word to send
    input wire logic send,
    input wire logic force_raw,
    input wire logic [5:0] rsv,
    input wire logic [7:0] control,
    input wire logic [63:0] payload,
    // Lane bus
    output logic [79:0] lane_tx_input_bus
);
    // Idle: strobe low, data lines show the inverse of the held word
    assign lane_tx_input_bus = send ? {1'b1, rsv, force_raw, control, payload}
        : {1'b0, 6'h00, ~force_raw, ~control, ~payload};
endmodule
